//--- pkg/lcdcs_pkg.sv
// constants and types for the display command options and cascade sync block
package lcdcs_pkg;
	// ********************************
	// register map
	// ********************************
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_START = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h08;
	localparam logic [7:0] ADDR_OPTS = 8'h0C;
	localparam logic [7:0] ADDR_STATE = 8'h10;
	// ********************************
	// drive modes and command fields
	// ********************************
	localparam logic [1:0] MODE_MUX4 = 2'h0;
	localparam logic [1:0] MODE_STATIC = 2'h1;
	localparam logic [1:0] MODE_MUX2 = 2'h2;
	localparam logic [1:0] MODE_MUX3 = 2'h3;
	localparam logic [1:0] MODE_RESET = 2'h1;
	localparam int CONT_BIT = 7;
	localparam logic [3:0] OPC_DEVSEL = 4'hC;
	localparam logic [4:0] OPC_BANK = 5'h1E;
	localparam logic [3:0] OPC_BLINK = 4'hE;
	localparam logic [1:0] RATE_OFF = 2'h0;
	localparam logic [1:0] RATE_2HZ = 2'h1;
	localparam logic [1:0] RATE_1HZ = 2'h2;
	localparam logic [2:0] SUBADDR_RESET = 3'h0;
	localparam logic [5:0] PTR_RESET = 6'h00;
	localparam logic [5:0] RAM_LAST = 6'h27;
	localparam int RAM_DEPTH = 40;
	// ********************************
	// timing
	// ********************************
	localparam int CLOCK_HZ = 10_000_000;
	localparam int BLINK_HALF_MS_2HZ = 250;
	localparam int BLINK_HALF_MS_1HZ = 500;
	localparam int BLINK_HALF_MS_05HZ = 1000;
	localparam int HALF_CYC_2HZ = BLINK_HALF_MS_2HZ * (CLOCK_HZ / 1000);
	localparam int HALF_CYC_1HZ = BLINK_HALF_MS_1HZ * (CLOCK_HZ / 1000);
	localparam int HALF_CYC_05HZ = BLINK_HALF_MS_05HZ * (CLOCK_HZ / 1000);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CMD = 3'b010,
		ST_DATA = 3'b100
	} lcdcs_xfer_t;
endpackage : lcdcs_pkg

//--- rtl/lcdcs_ctrl.sv
// display controller with command options and cascade frame sync
`timescale 1ns/100ps
`default_nettype none
module lcdcs_ctrl #(
	parameter int P_HALF_2HZ = lcdcs_pkg::HALF_CYC_2HZ,
	parameter int P_HALF_1HZ = lcdcs_pkg::HALF_CYC_1HZ,
	parameter int P_HALF_05HZ = lcdcs_pkg::HALF_CYC_05HZ
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_frame_clock,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_hw_subaddr_bit_zero,
	input wire logic i_hw_subaddr_bit_one,
	input wire logic i_hw_subaddr_bit_two,
	input wire logic i_slave_addr_lsb_pin,
	input wire logic i_sync_in,
	output logic o_sync_out,
	output logic o_sync_oe,
	output logic [3:0] o_row_drive_outputs,
	output logic [5:0] o_seg_addr,
	output logic [3:0] o_seg_bits,
	output logic o_blank,
	output logic o_out_bank
);
	// ********************************
	// helpers
	// ********************************
	// three- and four-way multiplex modes
	function automatic logic lcdcs_mux34(input logic [1:0] m);
		lcdcs_mux34 = (m == lcdcs_pkg::MODE_MUX3) || (m == lcdcs_pkg::MODE_MUX4);
	endfunction : lcdcs_mux34

	// index of last backplane phase
	function automatic logic [1:0] lcdcs_last(input logic [1:0] m);
		lcdcs_last = m - 2'h1;
	endfunction : lcdcs_last

	// ********************************
	// reset release and pin synchronisers
	// ********************************
	logic rst_s1_reg;
	logic rst_n;
	logic [3:0] pins_s1_reg;
	logic [3:0] pins_s2_reg;
	// two-flop reset release
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end

	// pins: slave lsb and hardware subaddress
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pins_s1_reg <= 4'h0;
			pins_s2_reg <= 4'h0;
		end
		else
		begin
			pins_s1_reg <= {i_slave_addr_lsb_pin, i_hw_subaddr_bit_two,
				i_hw_subaddr_bit_one, i_hw_subaddr_bit_zero};
			pins_s2_reg <= pins_s1_reg;
		end
	end

	// ********************************
	// command execution and ram fill
	// ********************************
	lcdcs_pkg::lcdcs_xfer_t xfer_reg, xfer_next;
	logic [2:0] subaddr_reg, subaddr_next;
	logic in_bank_reg, in_bank_next;
	logic out_bank_reg, out_bank_next;
	logic [1:0] rate_reg, rate_next;
	logic alt_reg, alt_next;
	logic [1:0] mode_reg, mode_next;
	logic [5:0] ptr_reg, ptr_next;
	logic [3:0] ram_reg [lcdcs_pkg::RAM_DEPTH];
	logic [3:0] ram_next [lcdcs_pkg::RAM_DEPTH];
	logic cmd_wr;
	logic data_we;
	logic [2:0] bpa;
	logic [6:0] wa;
	logic [1:0] wb;
	logic [6:0] step_end;
	// decode one byte as command or display data
	always_comb
	begin
		xfer_next = xfer_reg;
		subaddr_next = subaddr_reg;
		in_bank_next = in_bank_reg;
		out_bank_next = out_bank_reg;
		rate_next = rate_reg;
		alt_next = alt_reg;
		mode_next = mode_reg;
		ptr_next = ptr_reg;
		ram_next = ram_reg;
		wa = 7'h00;
		wb = 2'h0;
		cmd_wr = i_wr && (i_addr == lcdcs_pkg::ADDR_CMD);
		data_we = 1'b0;
		case (mode_reg)
			lcdcs_pkg::MODE_STATIC: bpa = 3'h1;
			lcdcs_pkg::MODE_MUX2: bpa = 3'h2;
			lcdcs_pkg::MODE_MUX3: bpa = 3'h3;
			default: bpa = 3'h4;
		endcase
		step_end = 7'(ptr_reg) + 7'((8 + int'(bpa) - 1) / int'(bpa));
		if (i_wr && (i_addr == lcdcs_pkg::ADDR_START))
		begin
			// other slave lsb ignores the whole transfer
			if (i_wdata[0] == pins_s2_reg[3])
				xfer_next = lcdcs_pkg::ST_CMD;
			else
				xfer_next = lcdcs_pkg::ST_IDLE;
		end
		else if (i_wr && (i_addr == lcdcs_pkg::ADDR_MODE))
			mode_next = i_wdata[1:0];
		else if (cmd_wr && (xfer_reg == lcdcs_pkg::ST_CMD))
		begin
			if (!i_wdata[lcdcs_pkg::CONT_BIT])
				xfer_next = lcdcs_pkg::ST_DATA;
			if (i_wdata[6:3] == lcdcs_pkg::OPC_DEVSEL)
				subaddr_next = i_wdata[2:0];
			else if ((i_wdata[6:2] == lcdcs_pkg::OPC_BANK)
				&& !lcdcs_mux34(mode_reg))
			begin
				in_bank_next = i_wdata[1];
				out_bank_next = i_wdata[0];
			end
			else if (i_wdata[6:3] == lcdcs_pkg::OPC_BLINK)
			begin
				alt_next = i_wdata[2];
				rate_next = i_wdata[1:0];
			end
		end
		else if (cmd_wr && (xfer_reg == lcdcs_pkg::ST_DATA))
		begin
			// only the matching subaddress stores the byte
			data_we = (subaddr_reg == pins_s2_reg[2:0]);
			for (int i = 0; i < 8; i++)
			begin
				wa = 7'(ptr_reg) + 7'(i / int'(bpa));
				wb = 2'(i % int'(bpa));
				if (!lcdcs_mux34(mode_reg))
					wb = wb + {in_bank_reg, 1'b0};
				if (data_we && (wa <= 7'(lcdcs_pkg::RAM_LAST)))
					ram_next[wa[5:0]][wb] = i_wdata[7 - i];
			end
			// pointer advances in every device; subaddress advances only when the pointer wraps past RAM_LAST
			if (step_end > 7'(lcdcs_pkg::RAM_LAST))
			begin
				ptr_next = lcdcs_pkg::PTR_RESET;
				subaddr_next = subaddr_reg + 3'h1;
			end
			else
				ptr_next = step_end[5:0];
		end
	end

	// command state registers
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xfer_reg <= lcdcs_pkg::ST_IDLE;
			subaddr_reg <= lcdcs_pkg::SUBADDR_RESET;
			in_bank_reg <= 1'b0;
			out_bank_reg <= 1'b0;
			rate_reg <= lcdcs_pkg::RATE_OFF;
			alt_reg <= 1'b0;
			mode_reg <= lcdcs_pkg::MODE_RESET;
			ptr_reg <= lcdcs_pkg::PTR_RESET;
			for (int i = 0; i < lcdcs_pkg::RAM_DEPTH; i++)
				ram_reg[i] <= 4'h0;
		end
		else
		begin
			xfer_reg <= xfer_next;
			subaddr_reg <= subaddr_next;
			in_bank_reg <= in_bank_next;
			out_bank_reg <= out_bank_next;
			rate_reg <= rate_next;
			alt_reg <= alt_next;
			mode_reg <= mode_next;
			ptr_reg <= ptr_next;
			ram_reg <= ram_next;
		end
	end

	// ********************************
	// blink, fetch and register reads
	// ********************************
	logic [23:0] bcnt_reg, bcnt_next;
	logic bph_reg, bph_next;
	logic [23:0] half;
	logic [5:0] scan_reg, scan_next;
	logic [5:0] seg_addr_next;
	logic [3:0] seg_bits_next;
	logic blank_next;
	logic obank_next;
	logic [7:0] rdata_next;
	logic [3:0] word;
	// blink timer, bank alternation and display fetch
	always_comb
	begin
		case (rate_reg)
			lcdcs_pkg::RATE_2HZ: half = 24'(P_HALF_2HZ);
			lcdcs_pkg::RATE_1HZ: half = 24'(P_HALF_1HZ);
			default: half = 24'(P_HALF_05HZ);
		endcase
		bcnt_next = bcnt_reg + 24'h0001;
		bph_next = bph_reg;
		if (rate_reg == lcdcs_pkg::RATE_OFF)
		begin
			bcnt_next = 24'h0000;
			bph_next = 1'b0;
		end
		else if (bcnt_reg >= half - 24'h0001)
		begin
			bcnt_next = 24'h0000;
			bph_next = !bph_reg;
		end
		blank_next = (rate_reg != lcdcs_pkg::RATE_OFF) && !alt_reg
			&& bph_reg;
		obank_next = out_bank_reg ^ ((rate_reg != lcdcs_pkg::RATE_OFF)
			&& alt_reg && bph_reg && !lcdcs_mux34(mode_reg));
		scan_next = (scan_reg == lcdcs_pkg::RAM_LAST) ? 6'h00
			: scan_reg + 6'h01;
		seg_addr_next = scan_reg;
		word = ram_reg[scan_reg];
		if (lcdcs_mux34(mode_reg))
			seg_bits_next = word;
		else if (o_out_bank)
			seg_bits_next = {2'h0, word[3:2]};
		else
			seg_bits_next = {2'h0, word[1:0]};
		rdata_next = 8'h00;
		if (i_rd)
		begin
			case (i_addr)
				lcdcs_pkg::ADDR_MODE: rdata_next = {6'h00, mode_reg};
				lcdcs_pkg::ADDR_OPTS: rdata_next = {alt_reg, rate_reg,
					out_bank_reg, in_bank_reg, subaddr_reg};
				lcdcs_pkg::ADDR_STATE: rdata_next = {xfer_reg[2:1], ptr_reg};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// blink and output registers
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bcnt_reg <= 24'h0000;
			bph_reg <= 1'b0;
			scan_reg <= 6'h00;
			o_seg_addr <= 6'h00;
			o_seg_bits <= 4'h0;
			o_blank <= 1'b0;
			o_out_bank <= 1'b0;
			o_rdata <= 8'h00;
		end
		else
		begin
			bcnt_reg <= bcnt_next;
			bph_reg <= bph_next;
			scan_reg <= scan_next;
			o_seg_addr <= seg_addr_next;
			o_seg_bits <= seg_bits_next;
			o_blank <= blank_next;
			o_out_bank <= obank_next;
			o_rdata <= rdata_next;
		end
	end

	// ********************************
	// frame domain: backplane phases and sync
	// ********************************
	logic frst_s1_reg;
	logic frst_n;
	logic [1:0] mode_f1_reg;
	logic [1:0] mode_f2_reg;
	logic sync_f1_reg;
	logic sync_f2_reg;
	logic sync_f3_reg;
	logic [1:0] phase_reg, phase_next;
	logic [1:0] oe_d_reg, oe_d_next;
	logic oe_next;
	logic [3:0] row_next;
	logic [1:0] last;
	logic ext;
	// reset release in the frame domain
	always_ff @(posedge i_frame_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			frst_s1_reg <= 1'b0;
			frst_n <= 1'b0;
		end
		else
		begin
			frst_s1_reg <= 1'b1;
			frst_n <= frst_s1_reg;
		end
	end

	// phase stepping and foreign sync realignment
	always_comb
	begin
		last = lcdcs_last(mode_f2_reg);
		// falling sync that our own pulse cannot explain
		ext = !sync_f2_reg && sync_f3_reg && !o_sync_oe
			&& (oe_d_reg == 2'h0);
		if (ext)
			phase_next = last;
		else if (phase_reg >= last)
			phase_next = 2'h0;
		else
			phase_next = phase_reg + 2'h1;
		oe_next = (phase_next == last);
		oe_d_next = {oe_d_reg[0], o_sync_oe};
		row_next = 4'h1 << phase_next;
	end

	// frame registers; same reset state in every device
	always_ff @(posedge i_frame_clock or negedge frst_n)
	begin
		if (!frst_n)
		begin
			mode_f1_reg <= lcdcs_pkg::MODE_RESET;
			mode_f2_reg <= lcdcs_pkg::MODE_RESET;
			sync_f1_reg <= 1'b1;
			sync_f2_reg <= 1'b1;
			sync_f3_reg <= 1'b1;
			phase_reg <= 2'h0;
			oe_d_reg <= 2'h0;
			o_sync_oe <= 1'b0;
			o_sync_out <= 1'b0;
			o_row_drive_outputs <= 4'h1;
		end
		else
		begin
			mode_f1_reg <= mode_reg;
			mode_f2_reg <= mode_f1_reg;
			sync_f1_reg <= i_sync_in;
			sync_f2_reg <= sync_f1_reg;
			sync_f3_reg <= sync_f2_reg;
			phase_reg <= phase_next;
			oe_d_reg <= oe_d_next;
			o_sync_oe <= oe_next;
			o_sync_out <= 1'b0;
			o_row_drive_outputs <= row_next;
		end
	end

	// ********************************
	// assertions
	// ********************************
	logic is_cmd;
	logic is_data;
	assign is_cmd = cmd_wr && (xfer_reg == lcdcs_pkg::ST_CMD);
	assign is_data = cmd_wr && (xfer_reg == lcdcs_pkg::ST_DATA);

	property p_devsel;
		@(posedge i_clock) disable iff (!rst_n)
		is_cmd && (i_wdata[6:3] == lcdcs_pkg::OPC_DEVSEL)
		|=> subaddr_reg == $past(i_wdata[2:0]);
	endproperty
	a_devsel: assert property (p_devsel)
		else $error("device select did not load subaddress");

	property p_bank_ignore;
		@(posedge i_clock) disable iff (!rst_n)
		is_cmd && lcdcs_mux34(mode_reg)
		|=> $stable(in_bank_reg) && $stable(out_bank_reg);
	endproperty
	a_bank_ignore: assert property (p_bank_ignore)
		else $error("bank changed in three or four mux");

	property p_bank_set;
		@(posedge i_clock) disable iff (!rst_n)
		is_cmd && (i_wdata[6:2] == lcdcs_pkg::OPC_BANK)
		&& !lcdcs_mux34(mode_reg)
		|=> in_bank_reg == $past(i_wdata[1])
		&& out_bank_reg == $past(i_wdata[0]);
	endproperty
	a_bank_set: assert property (p_bank_set)
		else $error("bank select not applied");

	property p_blink;
		@(posedge i_clock) disable iff (!rst_n)
		is_cmd && (i_wdata[6:3] == lcdcs_pkg::OPC_BLINK)
		|=> rate_reg == $past(i_wdata[1:0]) && alt_reg == $past(i_wdata[2]);
	endproperty
	a_blink: assert property (p_blink)
		else $error("blink command not applied");

	property p_last_cmd;
		@(posedge i_clock) disable iff (!rst_n)
		is_cmd |=> (xfer_reg == lcdcs_pkg::ST_DATA)
		== !$past(i_wdata[lcdcs_pkg::CONT_BIT]);
	endproperty
	a_last_cmd: assert property (p_last_cmd)
		else $error("continuation flag misread");

	property p_alt_none;
		@(posedge i_clock) disable iff (!rst_n)
		lcdcs_mux34(mode_reg) ##1 $stable(mode_reg)
		|-> o_out_bank == $past(out_bank_reg);
	endproperty
	a_alt_none: assert property (p_alt_none)
		else $error("alternation active in three or four mux");

	property p_data_ignore;
		@(posedge i_clock) disable iff (!rst_n)
		is_data && (subaddr_reg != pins_s2_reg[2:0])
		|=> ram_reg[$past(ptr_reg)] == $past(ram_reg[ptr_reg]);
	endproperty
	a_data_ignore: assert property (p_data_ignore)
		else $error("data stored for other subaddress");

	property p_sync_phase;
		@(posedge i_frame_clock) disable iff (!frst_n)
		o_sync_oe == (phase_reg == lcdcs_last(mode_f2_reg))
		|| $changed(mode_f2_reg) || !$past(frst_n);
	endproperty
	a_sync_phase: assert property (p_sync_phase)
		else $error("sync not tied to last phase");

	property p_realign;
		@(posedge i_frame_clock) disable iff (!frst_n)
		ext && $stable(mode_f2_reg)
		|=> o_sync_oe && phase_reg == lcdcs_last(mode_f2_reg);
	endproperty
	a_realign: assert property (p_realign)
		else $error("foreign sync did not realign phase");
endmodule : lcdcs_ctrl
`default_nettype wire

//--- verif/lcdcs_peer.sv
// cascaded peer driver model sharing the sync wire
`timescale 1ns/100ps
`default_nettype none
module lcdcs_peer (
	input wire logic i_frame_clock,
	input wire logic i_arst_n,
	input wire logic [1:0] i_mode,
	input wire logic i_skew,
	output logic o_oe
);
	logic [1:0] rst_q;
	logic [1:0] m1_q;
	logic [1:0] m_q;
	logic [1:0] phase;
	logic [1:0] nxt;
	// last phase index is mode minus one for every drive mode
	always_comb
	begin
		nxt = (phase >= m_q - 2'h1) ? 2'h0 : phase + 2'h1;
		if (i_skew)
			nxt = (nxt >= m_q - 2'h1) ? 2'h0 : nxt + 2'h1;
	end
	// phase counter, released in step with the device at reset
	always @(posedge i_frame_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_q <= 2'b00;
			m1_q <= 2'h1;
			m_q <= 2'h1;
			phase <= 2'h0;
			o_oe <= 1'b0;
		end
		else
		begin
			rst_q <= {rst_q[0], 1'b1};
			m1_q <= i_mode;
			m_q <= m1_q;
			if (rst_q[1])
			begin
				phase <= nxt;
				o_oe <= (nxt == m_q - 2'h1);
			end
		end
	end
endmodule : lcdcs_peer
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the command options and cascade sync block
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic i_clock = 1'b0;
	logic i_frame_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [2:0] pins = 3'h0;
	logic lsb = 1'b0;
	logic [1:0] mode = 2'h1;
	logic skew = 1'b0;
	logic [7:0] o_rdata;
	logic o_sync_out;
	logic o_sync_oe;
	logic [3:0] o_row_drive_outputs;
	logic [5:0] o_seg_addr;
	logic [3:0] o_seg_bits;
	logic o_blank;
	logic o_out_bank;
	logic peer_oe;
	wire sync_w;
	int err_count = 0;
	int cmp_count = 0;
	int seed = 93;
	int hc [4] = '{0, 8, 16, 32};
	int n;
	logic [7:0] expq [$];
	logic rd_q = 1'b0;
	logic chk_sync = 1'b0;
	logic [5:0] ptr = 6'h00;
	logic [7:0] d;
	logic ok;
	// ************************************
	// clocks, wire and instances
	// ************************************
	always #50 i_clock = ~i_clock;
	initial
	begin
		#1.7;
		forever #3 i_frame_clock = ~i_frame_clock;
	end
	// open drain wire with pull-up
	assign sync_w = ~((o_sync_oe & ~o_sync_out) | peer_oe);
	lcdcs_ctrl #(.P_HALF_2HZ(8), .P_HALF_1HZ(16), .P_HALF_05HZ(32)) dut (
		.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_frame_clock(i_frame_clock), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_hw_subaddr_bit_zero(pins[0]), .i_hw_subaddr_bit_one(pins[1]),
		.i_hw_subaddr_bit_two(pins[2]), .i_slave_addr_lsb_pin(lsb),
		.i_sync_in(sync_w), .o_sync_out(o_sync_out),
		.o_sync_oe(o_sync_oe), .o_row_drive_outputs(o_row_drive_outputs),
		.o_seg_addr(o_seg_addr), .o_seg_bits(o_seg_bits),
		.o_blank(o_blank), .o_out_bank(o_out_bank));
	lcdcs_peer u_peer (.i_frame_clock(i_frame_clock), .i_arst_n(i_arst_n),
		.i_mode(mode), .i_skew(skew), .o_oe(peer_oe));
	// ************************************
	// tasks
	// ************************************
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] dd);
		i_wr <= w;
		i_rd <= r;
		i_addr <= a;
		i_wdata <= dd;
		@(posedge i_clock);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] dd);
		bus(1'b1, 1'b0, a, dd);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rd
	task automatic idle;
		bus(1'b0, 1'b0, 8'h00, 8'h00);
	endtask : idle
	// period of one blink half, blank or alternated bank
	task automatic tgl(input logic w, input int h);
		logic p;
		@(negedge i_clock);
		p = w ? o_out_bank : o_blank;
		n = 0;
		while ((w ? o_out_bank : o_blank) === p && n < 200)
		begin
			@(negedge i_clock);
			n++;
		end
		p = w ? o_out_bank : o_blank;
		n = 0;
		while ((w ? o_out_bank : o_blank) === p && n < 200)
		begin
			@(negedge i_clock);
			n++;
		end
		chk(n[7:0], h[7:0]);
	endtask : tgl
	// ************************************
	// result watchers
	// ************************************
	always @(posedge i_clock)
		rd_q <= i_rd;
	// read data stands the cycle after the strobe
	always @(negedge i_clock)
	begin
		if (rd_q === 1'b1)
			chk(o_rdata, expq.pop_front());
	end
	// sync pulled exactly in the last backplane phase
	always @(negedge i_frame_clock)
	begin
		if (chk_sync)
			chk({o_sync_out, o_sync_oe}, {1'b0, o_row_drive_outputs ==
				((mode == lcdcs_pkg::MODE_MUX4) ? 4'h8 : 4'h1)});
	end
	// ************************************
	// main sequence
	// ************************************
	initial
	begin
		pins = $random(seed);
		lsb = $random(seed);
		repeat (10) @(posedge i_clock);
		i_arst_n <= 1'b1;
		repeat (5) @(posedge i_clock);
		chk_sync <= 1'b1;
		rd(lcdcs_pkg::ADDR_OPTS, 8'h00);
		rd(lcdcs_pkg::ADDR_MODE, 8'h01);
		wr(lcdcs_pkg::ADDR_OPTS, 8'hFF);
		rd(lcdcs_pkg::ADDR_OPTS, 8'h00);
		rd(8'h20, 8'h00);
		// both banks: select, store, fetch
		for (int b = 0; b < 2; b++)
		begin
			d = $random(seed);
			wr(lcdcs_pkg::ADDR_START, {7'h00, lsb});
			wr(8'h00, {1'b1, 4'b1100, pins});
			wr(8'h00, {6'b011110, b[0], b[0]});
			wr(8'h00, d);
			rd(lcdcs_pkg::ADDR_OPTS, {3'h0, b[0], b[0], pins});
			ptr = ptr + 6'h08;
			rd(lcdcs_pkg::ADDR_STATE, {2'b10, ptr});
			idle();
			for (int i = 0; i < 8; i++)
			begin
				n = 0;
				while (o_seg_addr !== ptr - 6'h08 + i[5:0] && n < 400)
				begin
					@(negedge i_clock);
					n++;
				end
				// fetch scan never reached the address
				if (n >= 400)
					err_count++;
				chk({o_out_bank, o_seg_bits[0]}, {b[0], d[7 - i]});
			end
		end
		// wrong slave lsb: whole transfer ignored
		wr(lcdcs_pkg::ADDR_START, {7'h00, ~lsb});
		wr(8'h00, 8'h73);
		rd(lcdcs_pkg::ADDR_OPTS, {3'h3, pins});
		// data for another subaddress: pointer moves, nothing stored
		wr(lcdcs_pkg::ADDR_START, {7'h00, lsb});
		wr(8'h00, {1'b0, 4'b1100, pins + 3'h1});
		wr(8'h00, 8'hA5);
		ptr = ptr + 6'h08;
		rd(lcdcs_pkg::ADDR_STATE, {2'b10, ptr});
		rd(lcdcs_pkg::ADDR_OPTS, {3'h3, pins + 3'h1});
		wr(lcdcs_pkg::ADDR_START, {7'h00, lsb});
		wr(8'h00, {1'b0, 4'b1100, pins});
		// every blink rate, normal mode
		for (int r = 1; r < 4; r++)
		begin
			wr(lcdcs_pkg::ADDR_START, {7'h00, lsb});
			wr(8'h00, {5'b01110, 1'b0, r[1:0]});
			rd(lcdcs_pkg::ADDR_OPTS, {1'b0, r[1:0], 2'h3, pins});
			idle();
			tgl(1'b0, hc[r]);
		end
		wr(lcdcs_pkg::ADDR_START, {7'h00, lsb});
		wr(8'h00, 8'h70);
		idle();
		repeat (2) @(posedge i_clock);
		repeat (40) @(negedge i_clock) chk({7'h00, o_blank}, 8'h00);
		wr(lcdcs_pkg::ADDR_START, {7'h00, lsb});
		wr(8'h00, 8'h75);
		rd(lcdcs_pkg::ADDR_OPTS, {3'b101, 2'h3, pins});
		idle();
		tgl(1'b1, 8);
		// four way multiplex: banks and alternation frozen
		chk_sync <= 1'b0;
		wr(lcdcs_pkg::ADDR_MODE, {6'h00, lcdcs_pkg::MODE_MUX4});
		idle();
		mode <= lcdcs_pkg::MODE_MUX4;
		rd(lcdcs_pkg::ADDR_MODE, 8'h00);
		wr(lcdcs_pkg::ADDR_START, {7'h00, lsb});
		wr(8'h00, 8'h78);
		rd(lcdcs_pkg::ADDR_OPTS, {3'b101, 2'h3, pins});
		idle();
		repeat (4) @(posedge i_clock);
		chk_sync <= 1'b1;
		repeat (60) @(negedge i_clock) chk({7'h00, o_out_bank}, 8'h01);
		// peer slips a phase; device must realign to it
		ok = 1'b0;
		for (int t = 0; t < 3 && !ok; t++)
		begin
			@(negedge i_frame_clock);
			skew <= 1'b1;
			@(negedge i_frame_clock);
			skew <= 1'b0;
			repeat (24) @(negedge i_frame_clock);
			n = 0;
			repeat (8)
			begin
				@(negedge i_frame_clock);
				if (peer_oe === o_sync_oe)
					n++;
			end
			ok = (n == 8);
		end
		chk({7'h00, ok}, 8'h01);
		repeat (3) @(posedge i_clock);
		print_verdict();
	end
	// hang guard
	initial
	begin
		#5_000_000;
		err_count++;
		$display("wrong value at %0t: run did not finish", $time);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
